// File: pld_lock_device.sv
// lock detector device: serial register port, windowed coincidence lock counter, shared output pin
// assumes ref_edge/osc_edge are one-cycle pulses synchronous to aclk and the link obeys the host frame
//
// Notes on behaviour
// - setting training bit starts lock timer training
// - host retrains after comparison frequency change
// - edge pair inside window increments lock counter
// - either edge may lead; only spacing counts
// - lock when counter reaches threshold field
// - missed window clears counter, unlocks at once
// - host picks table entry nearest required window
// - host reprograms window when operating point changes
// - pin select code one drives lock flag
// - serial read temporarily takes over shared pin
// - force bit pins lock flag, no readback
// - detection works only with enable bit set
// - window timer runs only with timer bit
// - status register bit one shows lock
`timescale 1ns/100ps
module pld_lock_device #(
  parameter int TRAIN_PAIRS = 8,
  parameter int TRAIN_LIMIT = 16
) (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire logic     ref_edge,
  input  wire logic     osc_edge,
  output logic          lock_flag,
  pld_serial_if.device  link
);

  typedef enum logic [1:0] {PLD_IDLE, PLD_WAIT_OSC, PLD_WAIT_REF} pld_pair_t;

  localparam int W = pld_pkg::REG_W;
  localparam int E = pld_pkg::WIN_W;

  logic [W-1:0]               lock_cfg_q;
  logic [W-1:0]               pin_cfg_q;
  logic                       sck_q;
  logic [4:0]                 bit_cnt_q;
  logic [pld_pkg::FRAME_BITS-2:0] shift_q;
  logic [W-1:0]               out_q;
  logic                       reading_q;
  logic                       pin_q;
  logic                       lock_q;
  logic [2:0]                 cnt_q;
  pld_pair_t                  st_q, st_d;
  logic [E-1:0]               el_q, el_d;
  logic                       hit, miss;
  logic [E-1:0]               hit_el;
  logic                       train_prev_q, trained_q;
  logic [E-1:0]               train_max_q;
  logic [7:0]                 train_cnt_q;
  logic                       rise;
  logic [E-1:0]               window;
  logic                       en, timer_en, train_on, counting;
  logic [2:0]                 thresh;

  function automatic logic [W-1:0] read_mux(input logic [5:0] a, input logic [W-1:0] lc,
                                           input logic [W-1:0] pc, input logic lk);
    logic [W-1:0] v;
    v = '0;
    case (a)
      pld_pkg::LOCK_CFG_ADDR:  v = lc;
      pld_pkg::PIN_CFG_ADDR:   v = pc;
      pld_pkg::LOCK_STAT_ADDR: v[pld_pkg::STAT_LOCK] = lk;
      default:                 v = '0;
    endcase
    return v;
  endfunction : read_mux

  // ------------------------------------------------------------
  // serial port
  // ------------------------------------------------------------
  assign rise = link.serial_clk & ~sck_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= link.serial_clk;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_cnt_q <= '0;
      shift_q   <= '0;
      reading_q <= 1'b0;
      out_q     <= '0;
    end else if (link.serial_sel_n) begin
      bit_cnt_q <= '0;
      reading_q <= 1'b0;
    end else if (rise) begin
      shift_q   <= {shift_q[pld_pkg::FRAME_BITS-3:0], link.serial_data_in};
      bit_cnt_q <= bit_cnt_q + 5'h01;
      if (bit_cnt_q == '0) begin
        reading_q <= link.serial_data_in;
      end
      if (reading_q && bit_cnt_q == pld_pkg::ADDR_LAST_BIT) begin
        out_q <= read_mux({shift_q[4:0], link.serial_data_in}, lock_cfg_q, pin_cfg_q, lock_q);
      end else if (reading_q && bit_cnt_q >= pld_pkg::DATA_FIRST_BIT) begin
        out_q <= {out_q[W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cfg_q <= pld_pkg::LOCK_CFG_RESET;
      pin_cfg_q  <= pld_pkg::PIN_CFG_RESET;
    end else if (!link.serial_sel_n && rise && !reading_q && bit_cnt_q == pld_pkg::FRAME_LAST_BIT) begin
      case (shift_q[28:23])
        pld_pkg::LOCK_CFG_ADDR: lock_cfg_q <= {shift_q[22:0], link.serial_data_in};
        pld_pkg::PIN_CFG_ADDR:  pin_cfg_q  <= {shift_q[22:0], link.serial_data_in};
        default:                ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // shared output pin
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else if (pin_cfg_q[pld_pkg::PIN_FORCE]) begin
      pin_q <= lock_q;
    end else if (reading_q) begin
      pin_q <= out_q[W-1];
    end else begin
      pin_q <= (pin_cfg_q[pld_pkg::PIN_SEL_MSB:pld_pkg::PIN_SEL_LSB] == pld_pkg::PIN_SEL_LOCK) && lock_q;
    end
  end

  assign link.lock_or_read_out_pin = pin_q;
  assign lock_flag                 = lock_q;

  // ------------------------------------------------------------
  // coincidence window
  // ------------------------------------------------------------
  assign en       = lock_cfg_q[pld_pkg::DETECT_EN];
  assign timer_en = lock_cfg_q[pld_pkg::TIMER_EN];
  assign train_on = lock_cfg_q[pld_pkg::TRAIN_EN];
  assign thresh   = lock_cfg_q[pld_pkg::THRESH_MSB:pld_pkg::THRESH_LSB];
  assign counting = !train_on || trained_q;

  always_comb begin
    if (!train_on) begin
      window = pld_pkg::window_cycles(lock_cfg_q[pld_pkg::SPEED_MSB:pld_pkg::SPEED_LSB],
                                      lock_cfg_q[pld_pkg::DIV_MSB:pld_pkg::DIV_LSB]);
    end else if (trained_q) begin
      window = train_max_q + 1'b1;
    end else begin
      window = E'(TRAIN_LIMIT);
    end
  end

  always_comb begin
    hit    = 1'b0;
    miss   = 1'b0;
    hit_el = '0;
    st_d   = st_q;
    el_d   = el_q;
    if (!en || !timer_en) begin
      st_d = PLD_IDLE;
      el_d = '0;
    end else begin
      case (st_q)
        PLD_IDLE: begin
          if (ref_edge && osc_edge) begin
            hit = 1'b1;
          end else if (ref_edge) begin
            st_d = PLD_WAIT_OSC;
            el_d = E'(1);
          end else if (osc_edge) begin
            st_d = PLD_WAIT_REF;
            el_d = E'(1);
          end
        end
        PLD_WAIT_OSC, PLD_WAIT_REF: begin
          if ((st_q == PLD_WAIT_OSC) ? osc_edge : ref_edge) begin
            hit    = el_q < window;
            miss   = !(el_q < window);
            hit_el = el_q;
            st_d   = PLD_IDLE;
            el_d   = '0;
          end else if (el_q >= window || ((st_q == PLD_WAIT_OSC) ? ref_edge : osc_edge)) begin
            miss = 1'b1;
            st_d = PLD_IDLE;
            el_d = '0;
          end else begin
            el_d = el_q + 1'b1;
          end
        end
        default: begin
          st_d = PLD_IDLE;
          el_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= PLD_IDLE;
      el_q <= '0;
    end else begin
      st_q <= st_d;
      el_q <= el_d;
    end
  end

  // ------------------------------------------------------------
  // training
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      train_prev_q <= 1'b0;
      trained_q    <= 1'b0;
      train_max_q  <= '0;
      train_cnt_q  <= '0;
    end else begin
      train_prev_q <= train_on;
      if (train_on && !train_prev_q) begin
        trained_q   <= 1'b0;
        train_max_q <= '0;
        train_cnt_q <= '0;
      end else if (train_on && !trained_q && hit) begin
        if (hit_el > train_max_q) begin
          train_max_q <= hit_el;
        end
        train_cnt_q <= train_cnt_q + 8'h01;
        if (train_cnt_q == 8'(TRAIN_PAIRS - 1)) begin
          trained_q <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // lock counter
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      lock_q <= 1'b0;
    end else if (!en) begin
      cnt_q  <= '0;
      lock_q <= 1'b0;
    end else if (counting && miss) begin
      cnt_q  <= '0;
      lock_q <= 1'b0;
    end else if (counting && hit) begin
      if (cnt_q < thresh) begin
        cnt_q <= cnt_q + 3'h1;
      end
      lock_q <= ({1'b0, cnt_q} + 4'h1) >= {1'b0, thresh};
    end
  end

endmodule : pld_lock_device

// File: pld_pkg.sv
// constants shared by the lock detector device end and the host controller end
// assumes a single 25 mhz clock feeding both ends
package pld_pkg;

  // ------------------------------------------------------------
  // clock
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 40;
  localparam int CLK_PERIOD_TENTHS = CLK_PERIOD_NS * 10;

  // ------------------------------------------------------------
  // serial frame: rw bit, 6 address bits, 24 data bits, msb first
  // ------------------------------------------------------------
  localparam int REG_W       = 24;
  localparam int ADDR_BITS   = 6;
  localparam int FRAME_BITS  = 1 + ADDR_BITS + REG_W;
  localparam logic [4:0] ADDR_LAST_BIT  = 5'h06;
  localparam logic [4:0] DATA_FIRST_BIT = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h1e;

  // ------------------------------------------------------------
  // device register map
  // ------------------------------------------------------------
  localparam logic [5:0] LOCK_CFG_ADDR   = 6'h07;
  localparam logic [5:0] PIN_CFG_ADDR    = 6'h0f;
  localparam logic [5:0] LOCK_STAT_ADDR  = 6'h12;
  localparam logic [REG_W-1:0] LOCK_CFG_RESET = 24'h000000;
  localparam logic [REG_W-1:0] PIN_CFG_RESET  = 24'h000000;

  // lock_detect_config fields
  localparam int THRESH_LSB   = 0;
  localparam int THRESH_MSB   = 2;
  localparam int DIV_LSB      = 5;
  localparam int DIV_MSB      = 7;
  localparam int SPEED_LSB    = 8;
  localparam int SPEED_MSB    = 9;
  localparam int DETECT_EN    = 11;
  localparam int TIMER_EN     = 14;
  localparam int TRAIN_EN     = 20;

  // shared_pin_config fields
  localparam int PIN_SEL_LSB  = 0;
  localparam int PIN_SEL_MSB  = 4;
  localparam int PIN_FORCE    = 6;
  localparam logic [4:0] PIN_SEL_LOCK = 5'h01;

  // status register field
  localparam int STAT_LOCK    = 1;

  // ------------------------------------------------------------
  // nominal window per {speed, divide}, in tenths of ns
  // ------------------------------------------------------------
  localparam logic [11:0] WIN_TENTHS [32] = '{
    12'h041, 12'h050, 12'h06e, 12'h0aa, 12'h122, 12'h212, 12'h3e8, 12'h79e,
    12'h046, 12'h059, 12'h080, 12'h0d2, 12'h168, 12'h2a8, 12'h514, 12'h9f6,
    12'h047, 12'h05c, 12'h085, 12'h0dc, 12'h17c, 12'h2d0, 12'h564, 12'haa0,
    12'h04c, 12'h066, 12'h09a, 12'h104, 12'h1d6, 12'h370, 12'h6b8, 12'hd34
  };

  localparam int WIN_W = 8;

  function automatic logic [WIN_W-1:0] window_cycles(input logic [1:0] speed, input logic [2:0] div);
    int cyc;
    cyc = (int'(WIN_TENTHS[{speed, div}]) + CLK_PERIOD_TENTHS - 1) / CLK_PERIOD_TENTHS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[WIN_W-1:0];
  endfunction : window_cycles

  // ------------------------------------------------------------
  // host controller register map (axi4-lite, byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] HOST_CMD_OFF   = 4'h0;
  localparam logic [3:0] HOST_STAT_OFF  = 4'h4;
  localparam logic [3:0] HOST_RDATA_OFF = 4'h8;
  localparam int CMD_READ_BIT  = 31;
  localparam int CMD_ADDR_LSB  = 24;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_PIN      = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pld_pkg

// File: pld_serial_if.sv
// serial configuration link between host controller and lock detector device
// assumes both ends clocked by the same aclk; lock_or_read_out_pin is output-only
`timescale 1ns/100ps
interface pld_serial_if;
  logic serial_sel_n;
  logic serial_clk;
  logic serial_data_in;
  logic lock_or_read_out_pin;

  modport device (
    input  serial_sel_n,
    input  serial_clk,
    input  serial_data_in,
    output lock_or_read_out_pin
  );

  modport host (
    output serial_sel_n,
    output serial_clk,
    output serial_data_in,
    input  lock_or_read_out_pin
  );
endinterface : pld_serial_if

// File: pld_lock_host.sv
// host controller: axi4-lite command registers driving serial frames to the lock detector device
// assumes one aclk domain; software waits for busy low before issuing the next command
`timescale 1ns/100ps
module pld_lock_host #(
  parameter int SCK_HALF = 2
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  pld_serial_if.host       link
);

  typedef enum logic [1:0] {PLD_H_IDLE, PLD_H_LOW, PLD_H_HIGH, PLD_H_END} pld_host_t;

  pld_host_t                      st_q;
  logic [31:0]                    cmd_q;
  logic [pld_pkg::REG_W-1:0]      rx_q;
  logic [pld_pkg::FRAME_BITS-1:0] tx_q;
  logic [4:0]                     bit_q;
  logic [7:0]                     half_q;
  logic                           sel_n_q, sck_q, sdi_q;
  logic                           aw_have_q, w_have_q;
  logic [3:0]                     aw_addr_q;
  logic [31:0]                    w_data_q;
  logic [3:0]                     w_strb_q;
  logic                           start;
  logic [31:0]                    cmd_merged;

  assign link.serial_sel_n   = sel_n_q;
  assign link.serial_clk     = sck_q;
  assign link.serial_data_in = sdi_q;

  // ------------------------------------------------------------
  // axi4-lite write
  // ------------------------------------------------------------
  always_comb begin
    cmd_merged = cmd_q;
    for (int i = 0; i < 4; i++) begin
      if (w_strb_q[i]) begin
        cmd_merged[i*8 +: 8] = w_data_q[i*8 +: 8];
      end
    end
  end

  assign start = aw_have_q && w_have_q && !s_axi_bvalid && aw_addr_q == pld_pkg::HOST_CMD_OFF
                 && st_q == PLD_H_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pld_pkg::RESP_OKAY;
      cmd_q         <= '0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == pld_pkg::HOST_CMD_OFF) begin
          s_axi_bresp <= pld_pkg::RESP_OKAY;
          if (st_q == PLD_H_IDLE) begin
            cmd_q <= cmd_merged;
          end
        end else begin
          s_axi_bresp <= pld_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pld_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pld_pkg::RESP_OKAY;
        s_axi_rdata  <= '0;
        case (s_axi_araddr)
          pld_pkg::HOST_CMD_OFF:   s_axi_rdata <= cmd_q;
          pld_pkg::HOST_STAT_OFF: begin
            s_axi_rdata[pld_pkg::STAT_BUSY] <= st_q != PLD_H_IDLE;
            s_axi_rdata[pld_pkg::STAT_PIN]  <= link.lock_or_read_out_pin;
          end
          pld_pkg::HOST_RDATA_OFF: s_axi_rdata[pld_pkg::REG_W-1:0] <= rx_q;
          default:                 s_axi_rresp <= pld_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // serial frame engine
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= PLD_H_IDLE;
      sel_n_q <= 1'b1;
      sck_q   <= 1'b0;
      sdi_q   <= 1'b0;
      tx_q    <= '0;
      bit_q   <= '0;
      half_q  <= '0;
      rx_q    <= '0;
    end else begin
      case (st_q)
        PLD_H_IDLE: begin
          if (start) begin
            tx_q    <= {cmd_merged[pld_pkg::CMD_READ_BIT],
                        cmd_merged[pld_pkg::CMD_ADDR_LSB +: pld_pkg::ADDR_BITS],
                        cmd_merged[pld_pkg::REG_W-1:0]};
            sdi_q   <= cmd_merged[pld_pkg::CMD_READ_BIT];
            sel_n_q <= 1'b0;
            bit_q   <= '0;
            half_q  <= '0;
            st_q    <= PLD_H_LOW;
          end
        end
        PLD_H_LOW: begin
          half_q <= half_q + 8'h01;
          if (half_q == 8'(SCK_HALF - 1)) begin
            half_q <= '0;
            sck_q  <= 1'b1;
            if (bit_q >= pld_pkg::DATA_FIRST_BIT) begin
              rx_q <= {rx_q[pld_pkg::REG_W-2:0], link.lock_or_read_out_pin};
            end
            st_q <= PLD_H_HIGH;
          end
        end
        PLD_H_HIGH: begin
          half_q <= half_q + 8'h01;
          if (half_q == 8'(SCK_HALF - 1)) begin
            half_q <= '0;
            sck_q  <= 1'b0;
            if (bit_q == pld_pkg::FRAME_LAST_BIT) begin
              st_q <= PLD_H_END;
            end else begin
              bit_q <= bit_q + 5'h01;
              tx_q  <= {tx_q[pld_pkg::FRAME_BITS-2:0], 1'b0};
              sdi_q <= tx_q[pld_pkg::FRAME_BITS-2];
              st_q  <= PLD_H_LOW;
            end
          end
        end
        PLD_H_END: begin
          sel_n_q <= 1'b1;
          sdi_q   <= 1'b0;
          st_q    <= PLD_H_IDLE;
        end
        default: st_q <= PLD_H_IDLE;
      endcase
    end
  end

endmodule : pld_lock_host

// File: pld_lock_sva.sv
// assertions on the serial link and lock flag between the host and device ends
// assumes one aclk domain with a synchronous active-low reset
`timescale 1ns/100ps
module pld_lock_sva #(
  parameter int SCK_HALF = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_edge,
  input wire logic osc_edge,
  input wire logic lock_flag,
  input wire logic serial_sel_n,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic lock_or_read_out_pin
);
  localparam int FRAME_N = 31 * 2 * SCK_HALF + 1;
  logic [7:0] frame_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;

  // --------------------------------------------
  // cycle counters for frame and clock phases
  // --------------------------------------------
  always_ff @(posedge aclk) begin
    frame_q <= (!aresetn || serial_sel_n) ? 8'h00 : frame_q + 8'h01;
  end
  always_ff @(posedge aclk) begin
    hi_q <= (!aresetn || !serial_clk) ? 8'h00 : hi_q + 8'h01;
  end
  always_ff @(posedge aclk) begin
    lo_q <= (!aresetn || serial_sel_n || serial_clk) ? 8'h00 : lo_q + 8'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_idle_a: assert property ($rose(aresetn) |-> !lock_flag && serial_sel_n && !serial_clk)
    else $error("outputs not idle after reset");
  lock_rise_a: assert property ($rose(lock_flag) |-> $past(ref_edge || osc_edge))
    else $error("lock rose without an edge");
  pin_lock_a: assert property (serial_sel_n && $past(serial_sel_n, 3) && lock_or_read_out_pin |-> $past(lock_flag))
    else $error("pin high while unlocked");
  frame_len_a: assert property ($rose(serial_sel_n) |-> int'(frame_q) == FRAME_N)
    else $error("frame length wrong");
  sck_high_a: assert property ($fell(serial_clk) |-> int'(hi_q) == SCK_HALF)
    else $error("serial clock high phase wrong");
  sck_low_a: assert property ($rose(serial_clk) |-> int'(lo_q) == SCK_HALF)
    else $error("serial clock low phase wrong");
  data_stable_a: assert property (serial_clk |-> $stable(serial_data_in))
    else $error("data moved while clock high");
  sel_clk_a: assert property (serial_sel_n |-> !serial_clk)
    else $error("serial clock outside frame");
endmodule : pld_lock_sva

// File: test_pll_lock_detector.sv
// self-checking bench: host end and device end joined by the serial interface
// assumes a 25 mhz aclk and axi4-lite access to the host command registers
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_pll_lock_detector;
  logic        aclk, aresetn, ref_e, osc_e, lock_flag;
  logic [3:0]  awaddr, araddr, wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [23:0] dv;
  logic [2:0]  th;
  int          failures, check_count;

  pld_serial_if link_if();
  pld_lock_device #(.TRAIN_PAIRS(4), .TRAIN_LIMIT(16)) pld_lock_device_inst (.aclk(aclk), .aresetn(aresetn),
    .ref_edge(ref_e), .osc_edge(osc_e), .lock_flag(lock_flag), .link(link_if.device));
  pld_lock_host #(.SCK_HALF(2)) pld_lock_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link_if.host));
  pld_lock_sva #(.SCK_HALF(2)) pld_lock_sva_inst (.aclk(aclk), .aresetn(aresetn), .ref_edge(ref_e),
    .osc_edge(osc_e), .lock_flag(lock_flag), .serial_sel_n(link_if.serial_sel_n),
    .serial_clk(link_if.serial_clk), .serial_data_in(link_if.serial_data_in),
    .lock_or_read_out_pin(link_if.lock_or_read_out_pin));

  always #20 aclk = ~aclk;

  // --------------------------------------------
  // bus and stimulus tasks
  // --------------------------------------------
  task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // one serial frame, then wait until the host is idle again
  task dev(input logic rw, input logic [5:0] a, input logic [23:0] d, output logic [23:0] q);
    logic [31:0] s;
    logic [1:0]  r;
    axi_wr(pld_pkg::HOST_CMD_OFF, {rw, 1'b0, a, d}, r);
    do axi_rd(pld_pkg::HOST_STAT_OFF, s, r); while (s[pld_pkg::STAT_BUSY] !== 1'b0);
    axi_rd(pld_pkg::HOST_RDATA_OFF, s, r);
    q = s[23:0];
  endtask : dev

  // edge pair: d > 0 reference leads by d cycles, d < 0 oscillator leads
  task pair(input int d);
    int g;
    g = 10 + $urandom % 4;
    @(posedge aclk);
    ref_e <= (d >= 0);
    osc_e <= (d <= 0);
    if (d != 0) begin
      @(posedge aclk);
      ref_e <= 1'b0;
      osc_e <= 1'b0;
      repeat ((d > 0 ? d : -d) - 1) @(posedge aclk);
      ref_e <= (d < 0);
      osc_e <= (d > 0);
    end
    @(posedge aclk);
    ref_e <= 1'b0;
    osc_e <= 1'b0;
    repeat (g) @(posedge aclk);
  endtask : pair

  task pairs(input int n, input int d);
    for (int i = 0; i < n; i++) begin
      pair(i % 2 ? -d : d);
    end
  endtask : pairs

  // lock config word: ctl is {train, timer, detect}, win is {speed, divide}
  function automatic logic [23:0] cfg(input logic [2:0] ctl, input logic [4:0] win);
    return {3'h0, ctl[2], 5'h00, ctl[1], 2'h0, ctl[0], 1'b0, win, 2'h0, th};
  endfunction : cfg

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    print_verdict;
  end

  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial begin
    {aclk, aresetn, ref_e, osc_e, awvalid, wvalid, bready, arvalid, rready} = 9'h000;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hf;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(46));
    th = 3'(1 + $urandom % 7);
    axi_rd(4'hc, rd, rs);
    `CHK("rresp", pld_pkg::RESP_SLVERR, rs)
    `CHK("rdata", 32'h0, rd)
    axi_wr(4'hc, 32'h0, rs);
    `CHK("bresp", pld_pkg::RESP_SLVERR, rs)
    dev(1'b1, pld_pkg::LOCK_CFG_ADDR, 24'h0, dv);
    `CHK("lock cfg", pld_pkg::LOCK_CFG_RESET, dv)
    dev(1'b1, pld_pkg::PIN_CFG_ADDR, 24'h0, dv);
    `CHK("pin cfg", pld_pkg::PIN_CFG_RESET, dv)
    dev(1'b0, pld_pkg::PIN_CFG_ADDR, 24'h000001, dv);
    dev(1'b0, pld_pkg::LOCK_CFG_ADDR, cfg(3'b011, 5'h00), dv);
    pairs(int'(th) - 1, 0);
    `CHK("lock", 1'b0, lock_flag)
    pairs(1, 0);
    `CHK("lock", 1'b1, lock_flag)
    `CHK("pin", 1'b1, link_if.lock_or_read_out_pin)
    pairs(3, 0);
    `CHK("lock", 1'b1, lock_flag)
    dev(1'b1, pld_pkg::LOCK_STAT_ADDR, 24'h0, dv);
    `CHK("status", 1'b1, dv[1])
    dev(1'b1, pld_pkg::LOCK_CFG_ADDR, 24'h0, dv);
    `CHK("readback", cfg(3'b011, 5'h00), dv)
    axi_rd(pld_pkg::HOST_STAT_OFF, rd, rs);
    `CHK("pin", 1'b1, rd[pld_pkg::STAT_PIN])
    pairs(1, 3);
    `CHK("lock", 1'b0, lock_flag)
    pairs(int'(th) - 1, 0);
    `CHK("lock", 1'b0, lock_flag)
    pairs(1, 0);
    `CHK("lock", 1'b1, lock_flag)
    dev(1'b0, pld_pkg::LOCK_CFG_ADDR, cfg(3'b011, 5'h1f), dv);
    pairs(1, 20);
    `CHK("lock", 1'b0, lock_flag)
    pairs(int'(th), 3);
    `CHK("lock", 1'b1, lock_flag)
    dev(1'b0, pld_pkg::PIN_CFG_ADDR, 24'h000041, dv);
    dev(1'b1, pld_pkg::LOCK_CFG_ADDR, 24'h0, dv);
    `CHK("forced read", 24'hffffff, dv)
    `CHK("pin", 1'b1, link_if.lock_or_read_out_pin)
    dev(1'b0, pld_pkg::LOCK_CFG_ADDR, cfg(3'b010, 5'h00), dv);
    `CHK("lock", 1'b0, lock_flag)
    pairs(int'(th), 0);
    `CHK("lock", 1'b0, lock_flag)
    `CHK("pin", 1'b0, link_if.lock_or_read_out_pin)
    dev(1'b0, pld_pkg::LOCK_CFG_ADDR, cfg(3'b001, 5'h00), dv);
    pairs(int'(th) + 2, 0);
    `CHK("lock", 1'b0, lock_flag)
    dev(1'b0, pld_pkg::LOCK_CFG_ADDR, cfg(3'b011, 5'h00), dv);
    dev(1'b0, pld_pkg::LOCK_CFG_ADDR, cfg(3'b111, 5'h00), dv);
    pairs(4 + int'(th), 2);
    `CHK("lock", 1'b1, lock_flag)
    print_verdict;
  end
endmodule : test_pll_lock_detector
